/* hdl/sbmsc_cfg.svh */
// Operation
// R1 - Select bit 0: sleep instruction enters sleep
// R2 - Select bit 1: sleep instruction enters standby
// R3 - External interrupt wake leaves select bit alone
// R4 - Software clears select bit by writing 0
// R5 - Bits 6..4 choose wake settling wait
// R6 - Codes 000..101 give 8192..262144 states
// R7 - Code 110 reserved, code 111 16 states
// R8 - Software picks wait of 8/2 ms
// R9 - Standby bit 3 writable, resets to 1
// R10 - Standby bits 2..0 read 0, unwritable
// R11 - Stop bit 1 stops module, 0 releases
// R12 - Register A bit map of stopped modules
// R13 - Register B bits 7, 5 serial channels
// R14 - Register C bits 4, 3, 2 map
// R15 - Reset: A bits 7,6 zero, others one
// R16 - A top bit writable, resets 0
// R17 - Other unused stop bits writable, reset 1
// R18 - Wake: restart oscillator, wait, then resume
// R19 - Reset-type modules initialised, others retained
// R20 - Each stop bit exported, next cycle
// R21 - Sleep request reports sleep or standby
`ifndef SBMSC_CFG_SVH
`define SBMSC_CFG_SVH

`define SBMSC_ADDR_W      3
`define SBMSC_OFS_STBY    3'h0
`define SBMSC_OFS_STOP_A  3'h1
`define SBMSC_OFS_STOP_B  3'h2
`define SBMSC_OFS_STOP_C  3'h3

`define SBMSC_STBY_RST    8'h08
`define SBMSC_STBY_WMASK  8'hf8
`define SBMSC_SEL_BIT     7
`define SBMSC_WSEL_HI     6
`define SBMSC_WSEL_LO     4

`define SBMSC_STOP_A_RST  8'h3f
`define SBMSC_STOP_B_RST  8'hff
`define SBMSC_STOP_C_RST  8'hff

`define SBMSC_A_XFER      6
`define SBMSC_A_PTIMER    5
`define SBMSC_A_TLOW      4
`define SBMSC_A_PGEN      3
`define SBMSC_A_ADC       1
`define SBMSC_A_THIGH     0
`define SBMSC_B_SER0      7
`define SBMSC_B_SER2      5
`define SBMSC_C_BRK       4
`define SBMSC_C_CAN       3
`define SBMSC_C_SSU       2

// Settling waits in system clock states (8192 .. 262144, and 16)
`define SBMSC_WAIT_W      19
`define SBMSC_WAIT0       19'h02000
`define SBMSC_WAIT1       19'h04000
`define SBMSC_WAIT2       19'h08000
`define SBMSC_WAIT3       19'h10000
`define SBMSC_WAIT4       19'h20000
`define SBMSC_WAIT5       19'h40000
`define SBMSC_WAIT7       19'h00010

`endif

/* hdl/sbmsc_pkg.sv */
package sbmsc_pkg;

  typedef enum logic [1:0] {
    PWR_RUN    = 2'b00,
    PWR_SLEEP  = 2'b01,
    PWR_STBY   = 2'b10,
    PWR_SETTLE = 2'b11
  } sbmsc_state_t;

  typedef struct packed {
    logic xfer_ctrl;
    logic pulse_timer;
    logic timer_pair_low;
    logic pulse_gen;
    logic adc;
    logic timer_pair_high;
    logic serial_ch0;
    logic serial_ch2;
    logic break_ctrl;
    logic can_ctrl;
    logic sync_serial;
  } sbmsc_stop_t;

endpackage

/* hdl/sbmsc_top.sv */
`timescale 1ns/10ps
`include "sbmsc_cfg.svh"

module sbmsc_top #(
  parameter logic [`SBMSC_WAIT_W-1:0] WAIT_0 = `SBMSC_WAIT0,
  parameter logic [`SBMSC_WAIT_W-1:0] WAIT_1 = `SBMSC_WAIT1,
  parameter logic [`SBMSC_WAIT_W-1:0] WAIT_2 = `SBMSC_WAIT2,
  parameter logic [`SBMSC_WAIT_W-1:0] WAIT_3 = `SBMSC_WAIT3,
  parameter logic [`SBMSC_WAIT_W-1:0] WAIT_4 = `SBMSC_WAIT4,
  parameter logic [`SBMSC_WAIT_W-1:0] WAIT_5 = `SBMSC_WAIT5
) (
  input  wire logic                     clk,           // System clock
  input  wire logic                     reset,         // Async reset, high
  input  wire logic [`SBMSC_ADDR_W-1:0] reg_addr,      // Register address
  input  wire logic [7:0]               reg_wdata,     // Write data
  input  wire logic                     reg_wr,        // Write strobe
  input  wire logic                     reg_rd,        // Read strobe
  output logic      [7:0]               reg_rdata,     // Read data, next cycle
  input  wire logic                     sleep_req,     // Sleep instruction pulse
  input  wire logic                     irq_any,       // Any accepted interrupt
  input  wire logic                     ext_wake,      // External interrupt pulse
  output logic                          enter_sleep,   // Sleep entered pulse
  output logic                          enter_standby, // Standby entered pulse
  output logic                          cpu_halt,      // CPU halted
  output logic                          osc_stop,      // Oscillator stopped
  output logic                          settling,      // Settling wait running
  output logic                          irq_go,        // Start interrupt handling
  output logic      [7:0]               stop_a,        // Stop lines, register A
  output logic      [7:0]               stop_b,        // Stop lines, register B
  output logic      [7:0]               stop_c,        // Stop lines, register C
  output sbmsc_pkg::sbmsc_stop_t        stop_req,      // Named stop requests
  output sbmsc_pkg::sbmsc_stop_t        periph_init    // Initialise request
);

  logic [7:0] stby_ff;
  logic [7:0] nxt_stby;
  logic [7:0] stop_a_ff;
  logic [7:0] nxt_stop_a;
  logic [7:0] stop_b_ff;
  logic [7:0] nxt_stop_b;
  logic [7:0] stop_c_ff;
  logic [7:0] nxt_stop_c;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  sbmsc_pkg::sbmsc_state_t state_ff;
  sbmsc_pkg::sbmsc_state_t nxt_state;
  logic                    irq_go_ff;
  logic                    nxt_irq_go;
  logic                    ent_sleep_ff;
  logic                    nxt_ent_sleep;
  logic                    ent_stby_ff;
  logic                    nxt_ent_stby;
  logic                    tmr_start;
  logic                    tmr_busy;
  logic                    tmr_done;
  logic                    sel_standby;
  logic [2:0]              wsel;
  logic [`SBMSC_WAIT_W-1:0] wait_len;
  logic                    stby_halt;

  // Register file
  always_comb begin
    nxt_stby   = stby_ff;
    nxt_stop_a = stop_a_ff;
    nxt_stop_b = stop_b_ff;
    nxt_stop_c = stop_c_ff;
    nxt_rdata  = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        // Low three bits never take write data; bit 3 stays writable
        `SBMSC_OFS_STBY:   nxt_stby = reg_wdata & `SBMSC_STBY_WMASK; // R10 R9 R4 R5
        `SBMSC_OFS_STOP_A: nxt_stop_a = reg_wdata; // R11 R16 R17
        `SBMSC_OFS_STOP_B: nxt_stop_b = reg_wdata; // R11 R17
        `SBMSC_OFS_STOP_C: nxt_stop_c = reg_wdata; // R11 R17
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `SBMSC_OFS_STBY:   nxt_rdata = stby_ff & `SBMSC_STBY_WMASK; // R10
        `SBMSC_OFS_STOP_A: nxt_rdata = stop_a_ff;
        `SBMSC_OFS_STOP_B: nxt_rdata = stop_b_ff;
        `SBMSC_OFS_STOP_C: nxt_rdata = stop_c_ff;
        default:           nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stby_ff   <= `SBMSC_STBY_RST; // R9
      stop_a_ff <= `SBMSC_STOP_A_RST; // R15 R16
      stop_b_ff <= `SBMSC_STOP_B_RST; // R15 R17
      stop_c_ff <= `SBMSC_STOP_C_RST; // R15 R17
      rdata_ff  <= 8'h00;
    end else begin
      stby_ff   <= nxt_stby;
      stop_a_ff <= nxt_stop_a;
      stop_b_ff <= nxt_stop_b;
      stop_c_ff <= nxt_stop_c;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign sel_standby = stby_ff[`SBMSC_SEL_BIT];
  assign wsel        = stby_ff[`SBMSC_WSEL_HI:`SBMSC_WSEL_LO];

  // Wait lookup; software must size it for the clock source in use (R8)
  always_comb begin
    unique case (wsel)
      3'h0: wait_len = WAIT_0; // R5 R6
      3'h1: wait_len = WAIT_1; // R6
      3'h2: wait_len = WAIT_2; // R6
      3'h3: wait_len = WAIT_3; // R6
      3'h4: wait_len = WAIT_4; // R6
      3'h5: wait_len = WAIT_5; // R6
      // Reserved code falls back to the code 101 wait (WAIT_5), the longest with default parameters, the safe side
      3'h6: wait_len = WAIT_5; // R7
      3'h7: wait_len = `SBMSC_WAIT7; // R7
    endcase
  end

  // Power state sequencing
  always_comb begin
    nxt_state     = state_ff;
    nxt_irq_go    = 1'b0;
    nxt_ent_sleep = 1'b0;
    nxt_ent_stby  = 1'b0;
    tmr_start     = 1'b0;
    unique case (state_ff)
      sbmsc_pkg::PWR_RUN: begin
        if (sleep_req) begin
          if (sel_standby) begin
            nxt_state    = sbmsc_pkg::PWR_STBY; // R2 R21
            nxt_ent_stby = 1'b1;
          end else begin
            nxt_state     = sbmsc_pkg::PWR_SLEEP; // R1 R21
            nxt_ent_sleep = 1'b1;
          end
        end
      end
      sbmsc_pkg::PWR_SLEEP: begin
        if (irq_any) begin
          nxt_state  = sbmsc_pkg::PWR_RUN;
          nxt_irq_go = 1'b1;
        end
      end
      sbmsc_pkg::PWR_STBY: begin
        // Only an external interrupt can restart the oscillator
        if (ext_wake) begin
          nxt_state = sbmsc_pkg::PWR_SETTLE; // R18
          tmr_start = 1'b1;
        end
      end
      sbmsc_pkg::PWR_SETTLE: begin
        // Select bit is not touched here, software clears it (R4)
        if (tmr_done) begin
          nxt_state  = sbmsc_pkg::PWR_RUN; // R18 R3
          nxt_irq_go = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff     <= sbmsc_pkg::PWR_RUN;
      irq_go_ff    <= 1'b0;
      ent_sleep_ff <= 1'b0;
      ent_stby_ff  <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      irq_go_ff    <= nxt_irq_go;
      ent_sleep_ff <= nxt_ent_sleep;
      ent_stby_ff  <= nxt_ent_stby;
    end
  end

  // Wait length is latched at start, so rewriting the field mid-wait is harmless
  sbmsc_wait_timer u_wait (
    .clk      (clk),
    .reset    (reset),
    .start    (tmr_start),
    .load_val (wait_len),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  assign stby_halt = (state_ff == sbmsc_pkg::PWR_STBY) ||
                     (state_ff == sbmsc_pkg::PWR_SETTLE);

  assign reg_rdata     = rdata_ff;
  assign enter_sleep   = ent_sleep_ff;
  assign enter_standby = ent_stby_ff;
  assign irq_go        = irq_go_ff;
  assign cpu_halt      = state_ff != sbmsc_pkg::PWR_RUN;
  assign osc_stop      = state_ff == sbmsc_pkg::PWR_STBY; // R18
  assign settling      = tmr_busy;

  assign stop_a = stop_a_ff; // R20
  assign stop_b = stop_b_ff; // R20
  assign stop_c = stop_c_ff; // R20

  assign stop_req.xfer_ctrl       = stop_a_ff[`SBMSC_A_XFER]; // R12
  assign stop_req.pulse_timer     = stop_a_ff[`SBMSC_A_PTIMER]; // R12
  assign stop_req.timer_pair_low  = stop_a_ff[`SBMSC_A_TLOW]; // R12
  assign stop_req.pulse_gen       = stop_a_ff[`SBMSC_A_PGEN]; // R12
  assign stop_req.adc             = stop_a_ff[`SBMSC_A_ADC]; // R12
  assign stop_req.timer_pair_high = stop_a_ff[`SBMSC_A_THIGH]; // R12
  assign stop_req.serial_ch0      = stop_b_ff[`SBMSC_B_SER0]; // R13
  assign stop_req.serial_ch2      = stop_b_ff[`SBMSC_B_SER2]; // R13
  assign stop_req.break_ctrl      = stop_c_ff[`SBMSC_C_BRK]; // R14
  assign stop_req.can_ctrl        = stop_c_ff[`SBMSC_C_CAN]; // R14
  assign stop_req.sync_serial     = stop_c_ff[`SBMSC_C_SSU]; // R14

  // Retained modules never get an init; serial channels get it for
  // their status and data part only, the module decides which
  assign periph_init.xfer_ctrl       = 1'b0; // R19
  assign periph_init.pulse_timer     = 1'b0;
  assign periph_init.timer_pair_low  = 1'b0;
  assign periph_init.pulse_gen       = 1'b0;
  assign periph_init.timer_pair_high = 1'b0;
  assign periph_init.break_ctrl      = 1'b0;
  assign periph_init.adc         = stby_halt; // R19
  assign periph_init.can_ctrl    = stby_halt;
  assign periph_init.serial_ch0  = stby_halt || stop_req.serial_ch0; // R19
  assign periph_init.serial_ch2  = stby_halt || stop_req.serial_ch2;
  assign periph_init.sync_serial = stby_halt || stop_req.sync_serial; // R19

  sleep_entry_a: assert property (@(posedge clk) disable iff (reset) // R1
    (state_ff == sbmsc_pkg::PWR_RUN) && sleep_req && !sel_standby
    |=> (state_ff == sbmsc_pkg::PWR_SLEEP) && enter_sleep && !enter_standby)
    else $error("sleep request did not enter sleep");

  standby_entry_a: assert property (@(posedge clk) disable iff (reset) // R2
    (state_ff == sbmsc_pkg::PWR_RUN) && sleep_req && sel_standby
    |=> osc_stop && enter_standby ##1 !enter_standby)
    else $error("sleep request did not enter standby");

  select_kept_a: assert property (@(posedge clk) disable iff (reset) // R3
    (state_ff == sbmsc_pkg::PWR_SETTLE) && tmr_done && sel_standby
    |=> (state_ff == sbmsc_pkg::PWR_RUN) && irq_go && sel_standby)
    else $error("select bit changed on wake");

  short_wait_a: assert property (@(posedge clk) disable iff (reset) // R7
    (state_ff == sbmsc_pkg::PWR_STBY) && ext_wake && (wsel == 3'h7) && !reg_wr
    |=> (settling && !irq_go) [*8] ##1 (settling && !irq_go) [*8] ##1 irq_go && !cpu_halt)
    else $error("code 111 wait is not 16 cycles");

  wait_load_a: assert property (@(posedge clk) disable iff (reset) // R6
    tmr_start && (wsel == 3'h0) |-> (wait_len == WAIT_0))
    else $error("code 000 wait length wrong");

  low_bits_a: assert property (@(posedge clk) disable iff (reset) // R10
    reg_rd && (reg_addr == `SBMSC_OFS_STBY) |=> (reg_rdata[2:0] == 3'h0))
    else $error("standby low bits not zero");

  stop_write_a: assert property (@(posedge clk) disable iff (reset) // R20
    reg_wr && (reg_addr == `SBMSC_OFS_STOP_B)
    |=> (stop_b == $past(reg_wdata)) && (stop_req.serial_ch0 == stop_b[7]))
    else $error("stop lines did not follow write");

  reset_vals_a: assert property (@(posedge clk) // R15
    reset |-> (stop_a == `SBMSC_STOP_A_RST) && (stop_c == `SBMSC_STOP_C_RST)
    && (stby_ff == `SBMSC_STBY_RST))
    else $error("reset values wrong");

  wake_order_a: assert property (@(posedge clk) disable iff (reset) // R18
    $rose(settling) |-> $past(osc_stop) && !osc_stop && cpu_halt)
    else $error("settling did not follow oscillator restart");

  init_serial_a: assert property (@(posedge clk) disable iff (reset) // R19
    osc_stop |-> periph_init.sync_serial && periph_init.adc && !periph_init.pulse_gen)
    else $error("standby init requests wrong");

  stby_write_a: assert property (@(posedge clk) disable iff (reset) // R9 R10
    reg_wr && (reg_addr == `SBMSC_OFS_STBY)
    |=> (stby_ff[7:3] == $past(reg_wdata[7:3])) && (stby_ff[2:0] == 3'h0))
    else $error("standby register write wrong");

  read_idle_a: assert property (@(posedge clk) disable iff (reset) // R10
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data not zero outside answer cycle");

  stop_a_write_a: assert property (@(posedge clk) disable iff (reset) // R11 R16
    reg_wr && (reg_addr == `SBMSC_OFS_STOP_A)
    |=> (stop_a == $past(reg_wdata)) && (stop_req.xfer_ctrl == stop_a[6]))
    else $error("stop register A did not follow write");

  stop_c_write_a: assert property (@(posedge clk) disable iff (reset) // R14
    reg_wr && (reg_addr == `SBMSC_OFS_STOP_C)
    |=> (stop_c == $past(reg_wdata)) && (stop_req.can_ctrl == stop_c[3]))
    else $error("stop register C did not follow write");

  stay_stby_a: assert property (@(posedge clk) disable iff (reset) // R18
    (state_ff == sbmsc_pkg::PWR_STBY) && !ext_wake |=> osc_stop && cpu_halt)
    else $error("standby left without external wake");

  settle_busy_a: assert property (@(posedge clk) disable iff (reset) // R18
    (state_ff == sbmsc_pkg::PWR_SETTLE) |-> settling && cpu_halt && !osc_stop)
    else $error("settling state without running wait");

endmodule

/* hdl/sbmsc_wait_timer.sv */
`timescale 1ns/10ps
`include "sbmsc_cfg.svh"

module sbmsc_wait_timer (
  input  wire logic                     clk,      // System clock
  input  wire logic                     reset,    // Async reset, high
  input  wire logic                     start,    // Load and run
  input  wire logic [`SBMSC_WAIT_W-1:0] load_val, // Cycles to count
  output logic                          busy,     // Counting
  output logic                          done      // Last counted cycle
);

  logic [`SBMSC_WAIT_W-1:0] cnt_ff;
  logic [`SBMSC_WAIT_W-1:0] nxt_cnt;
  logic                     busy_ff;
  logic                     nxt_busy;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    if (start) begin
      nxt_cnt  = load_val;
      nxt_busy = 1'b1;
    end else if (busy_ff) begin
      if (cnt_ff == `SBMSC_WAIT_W'h00001) begin
        nxt_busy = 1'b0;
      end else begin
        nxt_cnt = cnt_ff - `SBMSC_WAIT_W'h00001;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff  <= `SBMSC_WAIT_W'h00000;
      busy_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  assign busy = busy_ff;
  assign done = busy_ff && (cnt_ff == `SBMSC_WAIT_W'h00001);

endmodule

/* tb/sbmsc_cpu_model.sv */
`timescale 1ns/10ps

module sbmsc_cpu_model (
  input  wire logic       clk,       // System clock
  input  wire logic       reset,     // Async reset, high
  input  wire logic [1:0] cmd,       // 1 sleep, 2 interrupt, 3 external wake
  input  wire logic       cpu_halt,  // Halted status from the block
  output logic            sleep_req, // Sleep instruction pulse
  output logic            irq_any,   // Interrupt request pulse
  output logic            ext_wake   // External interrupt pulse
);
  logic sleep_ff, irq_ff, ext_ff;
  logic nxt_sleep, nxt_irq, nxt_ext;

  // A halted CPU cannot issue a second sleep instruction
  always_comb begin
    nxt_sleep = (cmd == 2'h1) && !cpu_halt;
    nxt_irq   = (cmd == 2'h2);
    nxt_ext   = (cmd == 2'h3);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_ff <= 1'b0;
      irq_ff   <= 1'b0;
      ext_ff   <= 1'b0;
    end else begin
      sleep_ff <= nxt_sleep;
      irq_ff   <= nxt_irq;
      ext_ff   <= nxt_ext;
    end
  end

  assign sleep_req = sleep_ff;
  assign irq_any   = irq_ff;
  assign ext_wake  = ext_ff;
endmodule

/* tb/sbmsc_tb_top.sv */
`timescale 1ns/10ps
`include "sbmsc_cfg.svh"

module sbmsc_tb_top;
  logic                     clk, reset, reg_wr, reg_rd, rd_seen;
  logic [`SBMSC_ADDR_W-1:0] reg_addr;
  logic [7:0]               reg_wdata, reg_rdata, stop_a, stop_b, stop_c, a_v, b_v, c_v;
  logic [1:0]               cmd;
  logic                     sleep_req, irq_any, ext_wake, enter_sleep, enter_standby;
  logic                     cpu_halt, osc_stop, settling, irq_go;
  sbmsc_pkg::sbmsc_stop_t   stop_req, periph_init;
  logic [7:0]               exp_q[$];
  int                       fail_count, samples_checked, k;
  integer                   seed;
  localparam int WT [8] = '{8192, 24, 28, 32, 36, 40, 40, 16};

  // Code 000 keeps its full length; the longer codes are shortened to save run time
  sbmsc_top #(.WAIT_1(19'd24), .WAIT_2(19'd28), .WAIT_3(19'd32),
    .WAIT_4(19'd36), .WAIT_5(19'd40)) dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
    .irq_any(irq_any), .ext_wake(ext_wake), .enter_sleep(enter_sleep),
    .enter_standby(enter_standby), .cpu_halt(cpu_halt), .osc_stop(osc_stop),
    .settling(settling), .irq_go(irq_go), .stop_a(stop_a), .stop_b(stop_b),
    .stop_c(stop_c), .stop_req(stop_req), .periph_init(periph_init));

  sbmsc_cpu_model cpu (
    .clk(clk), .reset(reset), .cmd(cmd), .cpu_halt(cpu_halt),
    .sleep_req(sleep_req), .irq_any(irq_any), .ext_wake(ext_wake));

  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Every call starts right after an edge and ends on the edge that takes it
  task automatic op(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic nap(input logic [7:0] sc, input int n);
    logic s;
    s = sc[7];
    op(1'b1, 1'b0, 3'h0, sc);
    cmd <= 2'h1;
    op(1'b0, 1'b0, 3'h0, 8'h00);
    cmd <= 2'h0;
    k = 0;
    do begin @(posedge clk); #1; k++; end while (!(enter_sleep | enter_standby) && k < 8);
    check(enter_standby, s);
    check(enter_sleep, !s);
    check(cpu_halt, 1'b1);
    @(posedge clk); #1;
    check(osc_stop, s);
    check(periph_init.adc, s);
    @(posedge clk);
    cmd <= s ? 2'h3 : 2'h2;
    @(posedge clk);
    cmd <= 2'h0;
    #1;
    k = 0;
    do begin @(posedge clk); #1; k++; end while (irq_go !== 1'b1 && k < 9000);
    check(k, n + 1);
    check(cpu_halt, 1'b0);
    @(posedge clk);
    rd(3'h0, sc & 8'hf8);
    op(1'b0, 1'b0, 3'h0, 8'h00);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) begin
      if (exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
      else check(1'b1, 1'b0);
    end
    rd_seen <= reg_rd;
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(25 * 20000);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict;
  end

  initial begin
    reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
    cmd = 2'h0; rd_seen = 1'b0; fail_count = 0; samples_checked = 0;
    seed = 32'h105c334d;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check(stop_a, 8'h3f);
    check(stop_b, 8'hff);
    check(stop_c, 8'hff);
    rd(3'h0, 8'h08);
    rd(3'h1, 8'h3f);
    rd(3'h2, 8'hff);
    rd(3'h3, 8'hff);
    rd(3'h5, 8'h00);
    op(1'b0, 1'b0, 3'h0, 8'h00);
    $display("reset values done");
    op(1'b1, 1'b0, 3'h0, 8'h7f);
    rd(3'h0, 8'h78);
    op(1'b1, 1'b0, 3'h0, 8'h00);
    rd(3'h0, 8'h00);
    op(1'b1, 1'b0, 3'h6, 8'hff);
    rd(3'h0, 8'h00);
    op(1'b0, 1'b0, 3'h0, 8'h00);
    $display("standby register done");
    for (int i = 0; i < 8; i++) begin
      // Software keeps the unused bits at their required values
      a_v = (8'($random(seed)) & 8'h7f) | 8'h04;
      b_v = 8'($random(seed)) | 8'h5f;
      c_v = 8'($random(seed)) | 8'he3;
      op(1'b1, 1'b0, 3'h1, a_v);
      op(1'b1, 1'b0, 3'h2, b_v);
      op(1'b1, 1'b0, 3'h3, c_v);
      rd(3'h1, a_v);
      rd(3'h2, b_v);
      rd(3'h3, c_v);
      op(1'b0, 1'b0, 3'h0, 8'h00);
      #1;
      check({stop_a, stop_b, stop_c}, {a_v, b_v, c_v});
      check(stop_req, {a_v[6:3], a_v[1:0], b_v[7], b_v[5], c_v[4:2]});
      @(posedge clk);
    end
    $display("module stop done");
    nap(8'h00, 0);
    for (int i = 0; i < 8; i++) nap({1'b1, i[2:0], 4'h0}, WT[i]);
    op(1'b1, 1'b0, 3'h0, 8'h00);
    rd(3'h0, 8'h00);
    op(1'b0, 1'b0, 3'h0, 8'h00);
    $display("sleep and standby done");
    repeat (3) @(posedge clk);
    give_verdict;
  end
endmodule
